// >>> core/nib_exec_pkg.sv
// Purpose: Shared constants for the nibble instruction execute unit
// Assumes: 9-bit instruction words, one word per instruction cycle
// Notes: Opcode values are the instruction codes of the subset
package nib_exec_pkg;
   // Single-word opcodes
   localparam logic [8:0] OP_NOP = 9'h000;
   localparam logic [8:0] OP_PDTEST = 9'h003;
   localparam logic [8:0] OP_LOGIC = 9'h041;
   localparam logic [8:0] OP_T1TEST = 9'h042;
   localparam logic [8:0] OP_RET = 9'h044;
   localparam logic [8:0] OP_RETSKIP = 9'h045;
   localparam logic [8:0] OP_T1LOAD = 9'h047;
   localparam logic [8:0] OP_T2TEST = 9'h052;
   localparam logic [8:0] OP_LSEL = 9'h058;
   localparam logic [8:0] OP_PORTG = 9'h080;
   localparam logic [8:0] OP_PORTE = 9'h084;
   // First words of the two-word instructions
   localparam logic [8:0] OP_CMP1 = 9'h025;
   localparam logic [8:0] OP_PDB1 = 9'h024;
   // Opcode groups matched on the upper bits
   localparam logic [4:0] GRP_ACC_LOAD = 5'h0B;
   localparam logic [2:0] GRP_PTR_LOAD = 3'h3;
   localparam logic [6:0] GRP_BCLR = 7'h13;
   localparam logic [6:0] GRP_BSET = 7'h17;
   localparam logic [6:0] GRP_BZERO = 7'h08;
   // Logic select encodings
   localparam logic [1:0] LSEL_XOR = 2'h0;
   localparam logic [1:0] LSEL_OR = 2'h1;
   localparam logic [1:0] LSEL_AND = 2'h2;
   // Values after reset
   localparam logic [10:0] RST_PC = 11'h000;
   localparam logic [3:0] RST_ACC = 4'h0;
   localparam logic [7:0] RST_T1 = 8'hFF;
   // Execute sequencer states
   typedef enum logic [3:0] {
      ST_EXEC = 4'h1,
      ST_RET = 4'h2,
      ST_WORD2 = 4'h4,
      ST_SKIP2 = 4'h8
   } exec_state_t;
endpackage : nib_exec_pkg

// >>> core/nib_exec.sv
// Purpose: Execute unit for a subset of a 4-bit controller instruction set
// Assumes: cycle_en_i pulses once per instruction cycle, instr_i is word at pc_o
// Notes: Stack pushes come from the call logic through stack_push_i
`timescale 1ns/1ps
module nib_exec #(
   parameter int RAM_WORDS = 64,
   parameter int STACK_DEPTH = 4
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic cycle_en_i,
   input wire logic [8:0] instr_i,
   input wire logic [3:0] reg_b_i,
   input wire logic [7:0] reg_e_i,
   input wire logic powerdown_flag_i,
   input wire logic timer1_run_bit_i,
   input wire logic timer1_tick_i,
   input wire logic timer2_request_i,
   input wire logic [7:0] port_d_i,
   input wire logic stack_push_i,
   input wire logic [10:0] stack_push_addr_i,
   output logic [10:0] pc_o,
   output logic [3:0] acc_o,
   output logic [1:0] row_o,
   output logic [3:0] col_o,
   output logic [1:0] logic_select_reg_o,
   output logic [1:0] port_e_o,
   output logic [3:0] port_g_o,
   output logic [7:0] timer1_count_o,
   output logic [7:0] timer1_reload_reg_o,
   output logic timer1_underflow_flag_o,
   output logic timer2_request_flag_o,
   output logic skip_o
);
   // Combine accumulator and E as selected; code 3 leaves A as is
   function automatic logic [3:0] logic_fn(input logic [1:0] sel, input logic [3:0] a,
                                           input logic [3:0] e);
      if (sel == nib_exec_pkg::LSEL_XOR) begin
         logic_fn = a ^ e;
      end else if (sel == nib_exec_pkg::LSEL_OR) begin
         logic_fn = a | e;
      end else if (sel == nib_exec_pkg::LSEL_AND) begin
         logic_fn = a & e;
      end else begin
         logic_fn = a;
      end
   endfunction : logic_fn

   nib_exec_pkg::exec_state_t state_q, state_d; // Sequencer
   logic [10:0] pc_q, pc_d;
   logic [3:0] acc_q, acc_d;
   logic [1:0] x_q, x_d; // Data pointer row
   logic [3:0] y_q, y_d; // Data pointer column
   logic [1:0] lsel_q, lsel_d;
   logic [1:0] pe_q, pe_d;
   logic [3:0] pg_q, pg_d;
   logic [7:0] t1c_q, t1c_d; // Timer 1 counter
   logic [7:0] t1r_q, t1r_d; // Timer 1 reload
   logic t1uf_q, t1uf_d; // Timer 1 underflow flag
   logic t2req_q, t2req_d; // Timer 2 request flag
   logic skip_q, skip_d; // Next word is to be skipped
   logic rskip_q, rskip_d; // Return in flight skips on arrival
   logic pdtest_q, pdtest_d; // Second word belongs to port D test
   logic acc_ld_prev_q, acc_ld_prev_d; // Previous word was an A load
   logic ptr_ld_prev_q, ptr_ld_prev_d; // Previous word was a pointer load
   logic [1:0] sp_q, sp_d;
   logic [10:0] stack_q [STACK_DEPTH];
   logic [3:0] ram_q [RAM_WORDS]; // Data memory, not cleared by reset
   logic [7:0] pd_s1_q, pd_s2_q, pd_s3_q, pd_q; // Port D sync and filter
   logic [7:0] pd_agree;
   logic ram_we;
   logic [3:0] ram_wd;
   logic [3:0] ram_rd;
   logic is_acc_ld, is_ptr_ld, two_word, act, ld_t1, uf;

   assign ram_rd = ram_q[{x_q, y_q}];
   assign is_acc_ld = (instr_i[8:4] == nib_exec_pkg::GRP_ACC_LOAD);
   assign is_ptr_ld = (instr_i[8:6] == nib_exec_pkg::GRP_PTR_LOAD);
   assign two_word = (instr_i == nib_exec_pkg::OP_CMP1) || (instr_i == nib_exec_pkg::OP_PDB1);
   // Word is executed for real in this cycle
   assign act = cycle_en_i && (state_q == nib_exec_pkg::ST_EXEC) && !skip_q;
   assign pd_agree = ~(pd_s2_q ^ pd_s3_q);

   // Next-state logic for the execute unit; port D filter, sync stages and stack writes are in the register block
   always_comb begin
      state_d = state_q;
      pc_d = pc_q;
      acc_d = acc_q;
      x_d = x_q;
      y_d = y_q;
      lsel_d = lsel_q;
      pe_d = pe_q;
      pg_d = pg_q;
      t1c_d = t1c_q;
      t1r_d = t1r_q;
      t1uf_d = t1uf_q;
      t2req_d = t2req_q;
      skip_d = skip_q;
      rskip_d = rskip_q;
      pdtest_d = pdtest_q;
      acc_ld_prev_d = acc_ld_prev_q;
      ptr_ld_prev_d = ptr_ld_prev_q;
      sp_d = sp_q;
      ram_we = 1'b0;
      ram_wd = ram_rd;
      ld_t1 = 1'b0;
      uf = 1'b0;
      if (stack_push_i) begin
         sp_d = sp_q + 2'h1;
      end
      if (cycle_en_i) begin
         pc_d = pc_q + 11'h001;
         acc_ld_prev_d = is_acc_ld;
         ptr_ld_prev_d = is_ptr_ld;
         case (state_q)
            nib_exec_pkg::ST_EXEC: begin
               if (skip_q) begin
                  skip_d = 1'b0;
                  if (two_word) begin
                     state_d = nib_exec_pkg::ST_SKIP2;
                  end
               end else if (is_acc_ld) begin
                  if (!acc_ld_prev_q) begin
                     acc_d = instr_i[3:0];
                  end
               end else if (is_ptr_ld) begin
                  if (!ptr_ld_prev_q) begin
                     x_d = instr_i[5:4];
                     y_d = instr_i[3:0];
                  end
               end else if (instr_i == nib_exec_pkg::OP_LOGIC) begin
                  acc_d = logic_fn(lsel_q, acc_q, reg_e_i[3:0]);
               end else if (instr_i == nib_exec_pkg::OP_LSEL) begin
                  lsel_d = acc_q[1:0];
               end else if (instr_i == nib_exec_pkg::OP_PORTE) begin
                  pe_d = acc_q[1:0];
               end else if (instr_i == nib_exec_pkg::OP_PORTG) begin
                  pg_d = acc_q;
               end else if (instr_i[8:2] == nib_exec_pkg::GRP_BSET) begin
                  ram_we = 1'b1;
                  ram_wd[instr_i[1:0]] = 1'b1;
               end else if (instr_i[8:2] == nib_exec_pkg::GRP_BCLR) begin
                  ram_we = 1'b1;
                  ram_wd[instr_i[1:0]] = 1'b0;
               end else if ((instr_i == nib_exec_pkg::OP_RET) ||
                            (instr_i == nib_exec_pkg::OP_RETSKIP)) begin
                  sp_d = sp_q - 2'h1;
                  rskip_d = instr_i[0];
                  state_d = nib_exec_pkg::ST_RET;
               end else if (two_word) begin
                  pdtest_d = (instr_i == nib_exec_pkg::OP_PDB1);
                  state_d = nib_exec_pkg::ST_WORD2;
               end else if (instr_i == nib_exec_pkg::OP_PDTEST) begin
                  skip_d = powerdown_flag_i;
               end else if (instr_i == nib_exec_pkg::OP_T1TEST) begin
                  skip_d = t1uf_q;
                  t1uf_d = 1'b0;
               end else if (instr_i == nib_exec_pkg::OP_T2TEST) begin
                  skip_d = t2req_q;
                  t2req_d = 1'b0;
               end else if (instr_i[8:2] == nib_exec_pkg::GRP_BZERO) begin
                  skip_d = !ram_rd[instr_i[1:0]];
               end else if (instr_i == nib_exec_pkg::OP_T1LOAD) begin
                  ld_t1 = 1'b1;
               end
               // Other words only advance the PC
            end
            nib_exec_pkg::ST_RET: begin
               pc_d = stack_q[sp_q];
               skip_d = rskip_q;
               state_d = nib_exec_pkg::ST_EXEC;
            end
            nib_exec_pkg::ST_WORD2: begin
               // Only indices four to seven test
               if (pdtest_q) begin
                  skip_d = (y_q[3:2] == 2'h1) && !pd_q[y_q[2:0]];
               end else begin
                  skip_d = (acc_q == instr_i[3:0]);
               end
               state_d = nib_exec_pkg::ST_EXEC;
            end
            nib_exec_pkg::ST_SKIP2: begin
               state_d = nib_exec_pkg::ST_EXEC;
            end
            default: begin
               state_d = nib_exec_pkg::ST_EXEC;
            end
         endcase
         // Operand words never start a load run
         if (state_q != nib_exec_pkg::ST_EXEC) begin
            acc_ld_prev_d = 1'b0;
            ptr_ld_prev_d = 1'b0;
         end
      end
      if (ld_t1) begin
         t1r_d = {reg_b_i, acc_q};
         if (!timer1_run_bit_i) begin
            t1c_d = {reg_b_i, acc_q};
         end
      end
      // Running counter keeps counting; a load while running leaves it alone
      if (timer1_run_bit_i && timer1_tick_i) begin
         if (t1c_q == 8'h00) begin
            t1c_d = t1r_q;
            uf = 1'b1;
         end else begin
            t1c_d = t1c_q - 8'h01;
         end
      end
      // Set wins over a clear in the same cycle
      if (uf) begin
         t1uf_d = 1'b1;
      end
      if (timer2_request_i) begin
         t2req_d = 1'b1;
      end
   end

   // Registers of the execute unit
   always_ff @(posedge sys_clk_i) begin
      pd_s1_q <= port_d_i;
      pd_s2_q <= pd_s1_q;
      pd_s3_q <= pd_s2_q;
      if (ram_we) begin
         ram_q[{x_q, y_q}] <= ram_wd;
      end
      if (sys_rst_i) begin
         state_q <= nib_exec_pkg::ST_EXEC;
         pc_q <= nib_exec_pkg::RST_PC;
         acc_q <= nib_exec_pkg::RST_ACC;
         x_q <= 2'h0;
         y_q <= 4'h0;
         lsel_q <= 2'h0;
         pe_q <= 2'h0;
         pg_q <= 4'h0;
         t1c_q <= nib_exec_pkg::RST_T1;
         t1r_q <= nib_exec_pkg::RST_T1;
         t1uf_q <= 1'b0;
         t2req_q <= 1'b0;
         skip_q <= 1'b0;
         rskip_q <= 1'b0;
         pdtest_q <= 1'b0;
         acc_ld_prev_q <= 1'b0;
         ptr_ld_prev_q <= 1'b0;
         sp_q <= 2'h0;
         pd_q <= 8'h00;
         for (int i = 0; i < STACK_DEPTH; i++) begin
            stack_q[i] <= nib_exec_pkg::RST_PC;
         end
      end else begin
         state_q <= state_d;
         pc_q <= pc_d;
         acc_q <= acc_d;
         x_q <= x_d;
         y_q <= y_d;
         lsel_q <= lsel_d;
         pe_q <= pe_d;
         pg_q <= pg_d;
         t1c_q <= t1c_d;
         t1r_q <= t1r_d;
         t1uf_q <= t1uf_d;
         t2req_q <= t2req_d;
         skip_q <= skip_d;
         rskip_q <= rskip_d;
         pdtest_q <= pdtest_d;
         acc_ld_prev_q <= acc_ld_prev_d;
         ptr_ld_prev_q <= ptr_ld_prev_d;
         sp_q <= sp_d;
         pd_q <= (pd_agree & pd_s3_q) | (~pd_agree & pd_q);
         if (stack_push_i) begin
            stack_q[sp_q] <= stack_push_addr_i;
         end
      end
   end

   assign pc_o = pc_q;
   assign acc_o = acc_q;
   assign row_o = x_q;
   assign col_o = y_q;
   assign logic_select_reg_o = lsel_q;
   assign port_e_o = pe_q;
   assign port_g_o = pg_q;
   assign timer1_count_o = t1c_q;
   assign timer1_reload_reg_o = t1r_q;
   assign timer1_underflow_flag_o = t1uf_q;
   assign timer2_request_flag_o = t2req_q;
   assign skip_o = skip_q;

   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_ret;
      act && (instr_i == nib_exec_pkg::OP_RETSKIP);
   endsequence
   sequence s_ret_done;
      (state_q == nib_exec_pkg::ST_RET) && cycle_en_i;
   endsequence

   AST_ACC_FIRST: assert property (act && is_acc_ld && !acc_ld_prev_q |=>
      acc_q == $past(instr_i[3:0]))
      else $error("first immediate load lost");
   AST_ACC_RUN: assert property (act && is_acc_ld && acc_ld_prev_q |=>
      $stable(acc_q))
      else $error("accumulator load in run not skipped");
   AST_PTR_RUN: assert property (act && is_ptr_ld && ptr_ld_prev_q |=>
      $stable(x_q) && $stable(y_q))
      else $error("pointer load in run not skipped");
   AST_LOGIC: assert property (act && instr_i == nib_exec_pkg::OP_LOGIC |=>
      acc_q == logic_fn($past(lsel_q), $past(acc_q), $past(reg_e_i[3:0])))
      else $error("logic result wrong");
   AST_PORTE: assert property (act && instr_i == nib_exec_pkg::OP_PORTE |=>
      pe_q == $past(acc_q[1:0]))
      else $error("port E not updated");
   // Return is split in two steps: the pop word, then the reload cycle
   AST_RETSKIP: assert property (s_ret |=> rskip_q &&
      (state_q == nib_exec_pkg::ST_RET))
      else $error("skip return not pending");
   AST_RETDONE: assert property (s_ret_done |=>
      (state_q == nib_exec_pkg::ST_EXEC) && (skip_q == $past(rskip_q)) &&
      (pc_q == $past(stack_q[sp_q])))
      else $error("return did not complete");
   AST_T1TEST: assert property (act && instr_i == nib_exec_pkg::OP_T1TEST &&
      t1uf_q && !uf |=> skip_q && !t1uf_q)
      else $error("timer 1 flag test wrong");
   AST_PDTEST: assert property (act && instr_i == nib_exec_pkg::OP_PDTEST |=>
      skip_q == $past(powerdown_flag_i))
      else $error("power-down test wrong");
   AST_T1STOP: assert property (act && instr_i == nib_exec_pkg::OP_T1LOAD &&
      !timer1_run_bit_i |=> t1c_q == {$past(reg_b_i), $past(acc_q)} && t1r_q == t1c_q)
      else $error("stopped timer load wrong");
   AST_T1RUN: assert property (act && instr_i == nib_exec_pkg::OP_T1LOAD &&
      timer1_run_bit_i && !timer1_tick_i |=>
      $stable(t1c_q) && t1r_q == {$past(reg_b_i), $past(acc_q)})
      else $error("running timer load wrong");
   AST_SKIPPED: assert property (cycle_en_i && skip_q &&
      state_q == nib_exec_pkg::ST_EXEC |=>
      $stable(acc_q) && $stable(pg_q) && $stable(pe_q) && !skip_q)
      else $error("skipped word changed state");
endmodule : nib_exec

// >>> tb/tb_nib_exec.sv
// Purpose: Self-checking bench for the nibble instruction execute unit
// Assumes: One word per cycle_en_i pulse, effects visible one clock after the taking edge
// Notes: Random operands from a fixed seed, with corner cases; RAM is only seen through skips
`timescale 1ns/1ps
module tb_nib_exec;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic cycle_en_i = 1'b0;
   logic [8:0] instr_i = 9'h000;
   logic [3:0] reg_b_i = 4'h0;
   logic [7:0] reg_e_i = 8'h00;
   logic powerdown_flag_i = 1'b0;
   logic timer1_run_bit_i = 1'b0;
   logic timer1_tick_i = 1'b0;
   logic timer2_request_i = 1'b0;
   logic [7:0] port_d_i = 8'h00;
   logic stack_push_i = 1'b0;
   logic [10:0] stack_push_addr_i = 11'h000;
   logic [10:0] pc_o;
   logic [3:0] acc_o, col_o, port_g_o;
   logic [1:0] row_o, logic_select_reg_o, port_e_o;
   logic [7:0] timer1_count_o, timer1_reload_reg_o;
   logic timer1_underflow_flag_o, timer2_request_flag_o, skip_o;
   int num_errors = 0;
   int checks_done = 0;
   int cyc = 0;
   logic [3:0] a, b, n;
   logic [1:0] x;
   logic [10:0] p;

   nib_exec DUT (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .cycle_en_i(cycle_en_i),
      .instr_i(instr_i), .reg_b_i(reg_b_i), .reg_e_i(reg_e_i),
      .powerdown_flag_i(powerdown_flag_i), .timer1_run_bit_i(timer1_run_bit_i),
      .timer1_tick_i(timer1_tick_i), .timer2_request_i(timer2_request_i),
      .port_d_i(port_d_i), .stack_push_i(stack_push_i),
      .stack_push_addr_i(stack_push_addr_i), .pc_o(pc_o), .acc_o(acc_o), .row_o(row_o),
      .col_o(col_o), .logic_select_reg_o(logic_select_reg_o), .port_e_o(port_e_o),
      .port_g_o(port_g_o), .timer1_count_o(timer1_count_o),
      .timer1_reload_reg_o(timer1_reload_reg_o),
      .timer1_underflow_flag_o(timer1_underflow_flag_o),
      .timer2_request_flag_o(timer2_request_flag_o), .skip_o(skip_o));

   // Free-running 125 MHz clock
   always #4 sys_clk_i = ~sys_clk_i;

   // Hang guard, far above the few hundred cycles the run needs
   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors = num_errors + 1;
         finish_test();
      end
   end

   // Verdict and end of run
   task finish_test();
      if (num_errors == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : finish_test

   // One comparison, reported at once on mismatch
   task check(input logic [10:0] seen, input logic [10:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         num_errors = num_errors + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Issue one word, cycle_en stays high so words run back to back
   task ex(input logic [8:0] w);
      @(posedge sys_clk_i);
      instr_i <= w;
      cycle_en_i <= 1'b1;
   endtask : ex

   // Stop issuing and let the last word land before sampling
   task idle();
      @(posedge sys_clk_i);
      cycle_en_i <= 1'b0;
      @(posedge sys_clk_i);
      #1;
   endtask : idle

   // Immediate load words
   function automatic logic [8:0] ld_acc(input logic [3:0] v);
      return {nib_exec_pkg::GRP_ACC_LOAD, v};
   endfunction : ld_acc

   function automatic logic [8:0] ld_ptr(input logic [1:0] r, input logic [3:0] c);
      return {nib_exec_pkg::GRP_PTR_LOAD, r, c};
   endfunction : ld_ptr

   // Expected logic operation result
   function automatic logic [3:0] lop(input logic [1:0] s, input logic [3:0] q,
                                      input logic [3:0] e);
      case (s)
         nib_exec_pkg::LSEL_XOR: return q ^ e;
         nib_exec_pkg::LSEL_OR: return q | e;
         nib_exec_pkg::LSEL_AND: return q & e;
         default: return q;
      endcase
   endfunction : lop

   initial begin
      void'($urandom(43173));
      repeat (4) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge sys_clk_i);
      #1;
      check(pc_o, nib_exec_pkg::RST_PC);
      check(11'(acc_o), 11'(nib_exec_pkg::RST_ACC));
      check(11'(timer1_count_o), 11'(nib_exec_pkg::RST_T1));
      check(11'(timer1_reload_reg_o), 11'(nib_exec_pkg::RST_T1));
      check(11'({skip_o, timer1_underflow_flag_o, timer2_request_flag_o}), 11'h000);
      // Runs of loads keep only the first word
      for (int i = 0; i < 6; i++) begin
         a = 4'($urandom);
         b = (i == 0) ? ~a : 4'($urandom);
         x = 2'($urandom);
         n = 4'($urandom);
         ex(nib_exec_pkg::OP_NOP);
         ex(ld_acc(a));
         ex(ld_acc(b));
         ex(ld_acc(~a));
         ex(ld_ptr(x, n));
         ex(ld_ptr(~x, ~n));
         idle();
         check(11'(acc_o), 11'(a));
         check(11'({row_o, col_o}), 11'({x, n}));
         // Ports take accumulator bits
         ex(nib_exec_pkg::OP_PORTE);
         ex(nib_exec_pkg::OP_PORTG);
         idle();
         check(11'(port_e_o), 11'(a[1:0]));
         check(11'(port_g_o), 11'(a));
         p = pc_o;
         ex(nib_exec_pkg::OP_NOP);
         idle();
         check(pc_o, p + 11'h001);
         check(11'(acc_o), 11'(a));
      end
      // Every logic select code against register E
      for (int s = 0; s < 4; s++) begin
         a = 4'($urandom);
         reg_e_i <= 8'($urandom);
         ex(nib_exec_pkg::OP_NOP);
         ex(ld_acc(4'(s)));
         ex(nib_exec_pkg::OP_LSEL);
         ex(ld_acc(a));
         ex(nib_exec_pkg::OP_LOGIC);
         idle();
         check(11'(logic_select_reg_o), 11'(s));
         check(11'(acc_o), 11'(lop(2'(s), a, reg_e_i[3:0])));
      end
      // Compare with equal and random operands
      for (int i = 0; i < 8; i++) begin
         a = 4'($urandom);
         n = (i < 2) ? a : 4'($urandom);
         ex(nib_exec_pkg::OP_NOP);
         ex(ld_acc(a));
         ex(nib_exec_pkg::OP_CMP1);
         ex(ld_acc(n));
         idle();
         check(11'(skip_o), 11'(a == n));
         check(11'(acc_o), 11'(a));
      end
      // Memory bit set, clear and zero test on every bit
      for (int j = 0; j < 4; j++) begin
         ex(nib_exec_pkg::OP_NOP);
         ex(ld_ptr(2'($urandom), 4'($urandom)));
         ex({nib_exec_pkg::GRP_BSET, 2'(j)});
         ex({nib_exec_pkg::GRP_BZERO, 2'(j)});
         idle();
         check(11'(skip_o), 11'h000);
         ex(nib_exec_pkg::OP_NOP);
         ex({nib_exec_pkg::GRP_BCLR, 2'(j)});
         ex({nib_exec_pkg::GRP_BZERO, 2'(j)});
         idle();
         check(11'(skip_o), 11'h001);
      end
      // Port D test, valid and out-of-range indices
      port_d_i <= 8'($urandom);
      repeat (5) @(posedge sys_clk_i);
      for (int y = 2; y < 8; y++) begin
         ex(nib_exec_pkg::OP_NOP);
         ex(ld_ptr(2'h0, 4'(y)));
         ex(nib_exec_pkg::OP_PDB1);
         ex(nib_exec_pkg::OP_NOP);
         idle();
         check(11'(skip_o), 11'((y > 3) && !port_d_i[y]));
      end
      // Power-down test skips a whole two-word instruction
      a = 4'($urandom);
      powerdown_flag_i <= 1'b1;
      ex(nib_exec_pkg::OP_NOP);
      ex(ld_acc(a));
      ex(nib_exec_pkg::OP_PDTEST);
      ex(nib_exec_pkg::OP_CMP1);
      ex(ld_acc(~a));
      ex(nib_exec_pkg::OP_PORTG);
      idle();
      check(11'(port_g_o), 11'(a));
      check(11'(skip_o), 11'h000);
      ex(nib_exec_pkg::OP_PDTEST);
      idle();
      check(11'(skip_o), 11'h001);
      ex(nib_exec_pkg::OP_NOP);
      powerdown_flag_i <= 1'b0;
      ex(nib_exec_pkg::OP_PDTEST);
      idle();
      check(11'(skip_o), 11'h000);
      // Stopped timer load, underflow, then running load
      reg_b_i <= 4'h0;
      ex(nib_exec_pkg::OP_NOP);
      ex(ld_acc(4'h1));
      ex(nib_exec_pkg::OP_T1LOAD);
      idle();
      check(11'({timer1_count_o, 3'h0}), 11'h008);
      check(11'(timer1_reload_reg_o), 11'h001);
      timer1_run_bit_i <= 1'b1;
      timer1_tick_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      timer1_tick_i <= 1'b0;
      idle();
      check(11'(timer1_underflow_flag_o), 11'h001);
      a = 4'($urandom);
      b = 4'($urandom);
      reg_b_i <= b;
      ex(ld_acc(a));
      ex(nib_exec_pkg::OP_T1LOAD);
      idle();
      check(11'(timer1_reload_reg_o), 11'({b, a}));
      check(11'(timer1_count_o), 11'h001);
      timer1_run_bit_i <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         ex(nib_exec_pkg::OP_NOP);
         ex(nib_exec_pkg::OP_T1TEST);
         idle();
         check(11'(skip_o), 11'(k == 0));
         check(11'(timer1_underflow_flag_o), 11'h000);
      end
      // Timer 2 request flag set, tested, cleared
      @(posedge sys_clk_i);
      timer2_request_i <= 1'b1;
      @(posedge sys_clk_i);
      timer2_request_i <= 1'b0;
      for (int k = 0; k < 2; k++) begin
         ex(nib_exec_pkg::OP_NOP);
         ex(nib_exec_pkg::OP_T2TEST);
         idle();
         check(11'(skip_o), 11'(k == 0));
         check(11'(timer2_request_flag_o), 11'h000);
      end
      // Both returns pop the pushed address
      for (int k = 0; k < 2; k++) begin
         p = 11'($urandom);
         @(posedge sys_clk_i);
         stack_push_addr_i <= p;
         stack_push_i <= 1'b1;
         @(posedge sys_clk_i);
         stack_push_i <= 1'b0;
         ex(nib_exec_pkg::OP_NOP);
         ex(k == 0 ? nib_exec_pkg::OP_RET : nib_exec_pkg::OP_RETSKIP);
         ex(nib_exec_pkg::OP_PORTG);
         idle();
         check(pc_o, p);
         check(11'(skip_o), 11'(k));
      end
      finish_test();
   end
endmodule : tb_nib_exec
